// [hw/gwf_cfg.svh]
// Offsets, field positions, reset values and timing counts of the pin block.
`ifndef GWF_CFG_SVH
`define GWF_CFG_SVH
`define GWF_CLK_MHZ        25
`define GWF_WAKE_MIN_NS    1000
`define GWF_WAKE_CYC       ((`GWF_WAKE_MIN_NS * `GWF_CLK_MHZ + 999) / 1000)
`define GWF_ABS_RES_UV     89
`define GWF_RATIO_SHIFT    16
`define GWF_ADDR_CFG_LO    12'h000
`define GWF_ADDR_CFG_HI    12'h004
`define GWF_ADDR_OUT       12'h008
`define GWF_ADDR_IN        12'h00C
`define GWF_ADDR_CTRL      12'h010
`define GWF_ADDR_STAT      12'h014
`define GWF_ADDR_MASK      12'h018
`define GWF_ADDR_ADC       12'h01C
`define GWF_ADDR_MEAS      12'h020
`define GWF_FN_AIN         2'h0
`define GWF_FN_DOUT        2'h1
`define GWF_FN_DIN         2'h2
`define GWF_CFG_RST        18'h1A006
`define GWF_CFG_LOCK_BOT   18'h18006
`define GWF_LOCK_MASK      18'h3C00F
`define GWF_CTRL_WAKE_EN   0
`define GWF_CTRL_SLEEP     1
`define GWF_CTRL_LFAULT    2
`define GWF_CTRL_RATIO     3
`define GWF_ST_WAKE        0
`define GWF_ST_FIN         1
`define GWF_ST_SLEEP       2
`endif

// [hw/gwf_pkg.sv]
// Types shared by the pin block modules.
package gwf_pkg;
    typedef enum logic [1:0] {
        GWF_PWR_SLEEP  = 2'b00,
        GWF_PWR_NORMAL = 2'b01
    } gwf_pwr_t;
    typedef logic [1:0] gwf_fn_t;
endpackage : gwf_pkg

// [hw/gwf_wake_if.sv]
// Wake-up signals passed between the top and the wake controller.
`timescale 1ns/1ps
interface gwf_wake_if;
    logic pin7_level;
    logic wake_armed;
    logic sleep_req;
    logic awake;
    logic wake_event;
    modport ctl (input pin7_level, wake_armed, sleep_req,
                 output awake, wake_event);
    modport top (output pin7_level, wake_armed, sleep_req,
                 input awake, wake_event);
endinterface : gwf_wake_if

// [hw/gwf_wake.sv]
// Wake controller: minimum high time filter and low-power state machine.
`timescale 1ns/1ps
`include "gwf_cfg.svh"
module gwf_wake #(
    parameter int WAKE_CYC = `GWF_WAKE_CYC
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Wake signals.
    gwf_wake_if.ctl  w
);
    logic [15:0]       cnt;
    gwf_pkg::gwf_pwr_t state;
    gwf_pkg::gwf_pwr_t next_state;
    wire  hold_high = w.wake_armed && w.pin7_level;
    wire  cnt_done  = cnt >= 16'(WAKE_CYC);

    // The count restarts on any low, so glitches never accumulate.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            cnt <= 16'h0000;
        else if (!hold_high)
            cnt <= 16'h0000; // [RULE13]
        else if (!cnt_done)
            cnt <= cnt + 16'h0001;
    end

    always_comb begin
        next_state = state;
        unique case (state)
            gwf_pkg::GWF_PWR_SLEEP: begin
                if (hold_high && cnt_done)
                    next_state = gwf_pkg::GWF_PWR_NORMAL; // [RULE4]
            end
            gwf_pkg::GWF_PWR_NORMAL: begin
                if (w.sleep_req && !hold_high)
                    next_state = gwf_pkg::GWF_PWR_SLEEP; // [RULE5] [RULE6]
            end
            default: next_state = gwf_pkg::GWF_PWR_NORMAL;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            state <= gwf_pkg::GWF_PWR_NORMAL;
        else
            state <= next_state;
    end

    assign w.awake      = (state == gwf_pkg::GWF_PWR_NORMAL);
    assign w.wake_event = (state == gwf_pkg::GWF_PWR_SLEEP) &&
                          (next_state == gwf_pkg::GWF_PWR_NORMAL);

    property p_stay_awake;
        @(posedge clk_sys) disable iff (rst)
        (hold_high && state == gwf_pkg::GWF_PWR_NORMAL) |=>
            state == gwf_pkg::GWF_PWR_NORMAL;
    endproperty
    a_stay_awake: assert property (p_stay_awake) // [RULE5]
        else $error("Device slept while pin 7 held wake.");

    property p_no_early_wake;
        @(posedge clk_sys) disable iff (rst)
        (state == gwf_pkg::GWF_PWR_SLEEP && !cnt_done) |=>
            state == gwf_pkg::GWF_PWR_SLEEP;
    endproperty
    a_no_early_wake: assert property (p_no_early_wake) // [RULE4]
        else $error("Wake before minimum high time.");

    property p_cnt_restart;
        @(posedge clk_sys) disable iff (rst)
        !hold_high |=> cnt == 16'h0000;
    endproperty
    a_cnt_restart: assert property (p_cnt_restart) // [RULE13]
        else $error("Wake counter not restarted on low.");

    property p_sleep_entry;
        @(posedge clk_sys) disable iff (rst)
        (state == gwf_pkg::GWF_PWR_NORMAL && w.sleep_req && !hold_high)
            |=> state == gwf_pkg::GWF_PWR_SLEEP;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) // [RULE6]
        else $error("Sleep request with pin 7 low ignored.");
endmodule : gwf_wake

// [hw/gwf_pinmux.sv]
// Per-pin direction and output selection with chain-bottom overrides.
`timescale 1ns/1ps
`include "gwf_cfg.svh"
module gwf_pinmux (
    // Configuration and levels.
    input  wire logic [17:0] cfg,
    input  wire logic [8:0]  out_val,
    input  wire logic        bottom,
    input  wire logic        sdo_val,
    input  wire logic        sdo_en,
    input  wire logic        fault_out,
    // Pin drive.
    output logic      [8:0]  pin_o,
    output logic      [8:0]  pin_oe
);
    genvar i;
    generate
        for (i = 0; i < 9; i++) begin : g_pin
            wire gwf_pkg::gwf_fn_t fn = cfg[2*i+1:2*i];
            wire is_out = (fn == `GWF_FN_DOUT); // [RULE1]
            if (i == 1) begin : g_fault
                assign pin_o[i]  = fault_out;  // [RULE8]
                assign pin_oe[i] = 1'b1;
            end else if (i == 8) begin : g_sdo
                assign pin_o[i]  = bottom ? sdo_val : out_val[i]; // [RULE2]
                assign pin_oe[i] = bottom ? sdo_en : is_out;
            end else begin : g_std
                assign pin_o[i]  = out_val[i];
                assign pin_oe[i] = is_out && !(bottom && i == 7); // [RULE2]
            end
        end
    endgenerate
endmodule : gwf_pinmux

// [hw/gwf_top.sv]
// General-purpose pin block with wake-up, fault relay and APB registers.
//
// Overview of operation
// RULE1: Each pin is a Schmitt digital input or buffered output per its config; pin 2 is always driven with fault out, whatever its config.
// RULE2: At chain bottom pin 8 is serial clock in, pin 9 serial data out.
// RULE3: Pin 7 wakes only with function input (10) and wake enable set.
// RULE4: Pin 7 high beyond the minimum wake time moves sleep to normal mode.
// RULE5: Pin 7 high with wake enabled keeps device awake despite sleep causes.
// RULE6: Sleep needs pin 7 low plus sleep command or communication timeout.
// RULE7: Fault from the upper device is sensed on pin 1.
// RULE8: Fault is passed down on pin 2, high meaning fault.
// RULE9: Absolute mode result step is 89 microvolts.
// RULE10: Ratiometric result step is two to the minus 16 of the reference.
// RULE11: Only pins 3 to 9 offer analog conversion.
// RULE12: At chain bottom the configs of pins 1, 2, 8, 9 are locked.
// RULE13: Wake minimum time is a counter restarting when pin 7 drops.
// RULE14: Fault out is high when fault in or a local fault is active.
`timescale 1ns/1ps
`include "gwf_cfg.svh"
module gwf_top #(
    parameter int WAKE_CYC = `GWF_WAKE_CYC
) (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins and chain.
    input  wire logic [8:0]  pin_i,
    output logic      [8:0]  pin_o,
    output logic      [8:0]  pin_oe,
    input  wire logic        serial_port_select_pin,
    input  wire logic        iso_link_minus_pin,
    input  wire logic        iso_link_plus_pin,
    input  wire logic        comm_timeout,
    // Analog conversion result.
    input  wire logic [15:0] adc_code,
    input  wire logic [3:0]  adc_pin,
    input  wire logic        adc_valid,
    // Serial port towards the slave core and power state.
    output logic             spi_sclk,
    output logic             spi_cs,
    output logic             spi_sdi,
    input  wire logic        spi_sdo,
    input  wire logic        spi_sdo_en,
    output logic             awake,
    output logic             irq
);
    logic [8:0]  pin_m;
    logic [8:0]  pin_s;
    logic [2:0]  ctl_m;
    logic [2:0]  ctl_s;
    logic [17:0] cfg;
    logic [8:0]  out_val;
    logic [3:0]  ctrl;
    logic [2:0]  stat;
    logic [2:0]  mask;
    logic [3:0]  meas_pin;
    logic [15:0] meas_code;
    logic [31:0] meas_uv;
    logic        sleep_cmd;
    logic [8:0]  next_pin_o;
    logic [8:0]  next_pin_oe;

    // Every pin and link input passes two flops before use.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_m <= 9'h000;
            pin_s <= 9'h000;
            ctl_m <= 3'h0;
            ctl_s <= 3'h0;
        end else begin
            pin_m <= pin_i;
            pin_s <= pin_m;
            ctl_m <= {serial_port_select_pin, iso_link_minus_pin,
                      iso_link_plus_pin};
            ctl_s <= ctl_m;
        end
    end

    wire bottom     = ctl_s[2];
    wire fault_in   = pin_s[0];                               // [RULE7]
    wire local_flt  = ctrl[`GWF_CTRL_LFAULT];
    wire fault_out  = fault_in || local_flt;                  // [RULE14]
    wire pin7_is_in = cfg[13:12] == `GWF_FN_DIN;
    wire wake_armed = pin7_is_in && ctrl[`GWF_CTRL_WAKE_EN];  // [RULE3]

    gwf_wake_if wif ();
    assign wif.pin7_level = pin_s[6];
    assign wif.wake_armed = wake_armed;
    assign wif.sleep_req  = sleep_cmd || comm_timeout;        // [RULE6]

    gwf_wake #(
        .WAKE_CYC (WAKE_CYC)
    ) u_wake (
        .clk_sys (clk_sys),
        .rst     (rst),
        .w       (wif.ctl)
    );

    gwf_pinmux u_mux (
        .cfg       (cfg),
        .out_val   (out_val),
        .bottom    (bottom),
        .sdo_val   (spi_sdo),
        .sdo_en    (spi_sdo_en),
        .fault_out (fault_out),
        .pin_o     (next_pin_o),
        .pin_oe    (next_pin_oe)
    );

    // APB decode; the slave answers in the access cycle with no wait.
    wire        wr      = psel && penable && pwrite;
    wire        rd_acc  = psel && !penable && !pwrite;
    wire        hit_clo = paddr == `GWF_ADDR_CFG_LO;
    wire        hit_chi = paddr == `GWF_ADDR_CFG_HI;
    wire        hit_out = paddr == `GWF_ADDR_OUT;
    wire        hit_in  = paddr == `GWF_ADDR_IN;
    wire        hit_ctl = paddr == `GWF_ADDR_CTRL;
    wire        hit_st  = paddr == `GWF_ADDR_STAT;
    wire        hit_msk = paddr == `GWF_ADDR_MASK;
    wire        hit_adc = paddr == `GWF_ADDR_ADC;
    wire        hit_ms  = paddr == `GWF_ADDR_MEAS;
    wire        mapped  = hit_clo | hit_chi | hit_out | hit_in | hit_ctl |
                          hit_st | hit_msk | hit_adc | hit_ms;
    wire [17:0] cfg_wr  = hit_clo ? {cfg[17:16], pwdata[15:0]}
                                  : {pwdata[1:0], cfg[15:0]};
    // Locked fields keep their fixed roles at chain bottom.
    wire [17:0] lock_v  = bottom ? `GWF_LOCK_MASK : 18'h00000;
    wire [17:0] next_cfg = (cfg_wr & ~lock_v) |
                           (`GWF_CFG_LOCK_BOT & lock_v);      // [RULE12]
    wire [17:0] cfg_fix = (cfg & ~lock_v) |
                          (`GWF_CFG_LOCK_BOT & lock_v);
    // Sleep entry is taken from the registered copy, so that a timeout
    // entry counts as well as a command.
    wire [2:0]  events  = {awake && !wif.awake, fault_in,
                           wif.wake_event};
    wire [2:0]  next_stat = (stat & ~(wr && hit_st ? pwdata[2:0] : 3'h0))
                            | events;
    // Analog results exist only for pins 3 to 9.
    wire        meas_ok = adc_valid && adc_pin >= 4'h3 &&
                          adc_pin <= 4'h9;                    // [RULE11]
    // Absolute: code times 89 uV; ratiometric: code over 2^16 of ref.
    wire [31:0] next_uv = ctrl[`GWF_CTRL_RATIO]
                          ? 32'(adc_code)                     // [RULE10]
                          : 32'(adc_code) * `GWF_ABS_RES_UV;  // [RULE9]

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg     <= `GWF_CFG_RST;
            out_val <= 9'h000;
            ctrl    <= 4'h0;
            mask    <= 3'h0;
        end else begin
            if (wr && (hit_clo || hit_chi))
                cfg <= next_cfg;                              // [RULE1]
            else
                cfg <= cfg_fix;
            if (wr && hit_out)
                out_val <= pwdata[8:0];
            if (wr && hit_ctl)
                ctrl <= {pwdata[3:2], 1'b0, pwdata[0]};
            if (wr && hit_msk)
                mask <= pwdata[2:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sleep_cmd <= 1'b0;
            stat      <= 3'h0;
            meas_pin  <= 4'h0;
            meas_code <= 16'h0000;
            meas_uv   <= 32'h00000000;
        end else begin
            sleep_cmd <= wr && hit_ctl && pwdata[`GWF_CTRL_SLEEP];
            stat      <= next_stat;
            if (meas_ok) begin
                meas_pin  <= adc_pin;
                meas_code <= adc_code;
                meas_uv   <= next_uv;
            end
        end
    end

    logic [31:0] rd_mux;
    assign rd_mux = hit_clo ? {16'h0000, cfg[15:0]} :
                    hit_chi ? {30'h0, cfg[17:16]} :
                    hit_out ? {23'h0, out_val} :
                    hit_in  ? {23'h0, pin_s} :
                    hit_ctl ? {28'h0000000, ctrl} :
                    hit_st  ? {29'h0, stat} :
                    hit_msk ? {29'h0, mask} :
                    hit_adc ? {12'h000, meas_pin, meas_code} :
                    hit_ms  ? meas_uv : 32'h00000000;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata   <= 32'h00000000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            pin_o    <= 9'h000;
            pin_oe   <= 9'h000;
            spi_sclk <= 1'b0;
            spi_cs   <= 1'b1;
            spi_sdi  <= 1'b0;
            awake    <= 1'b1;
            irq      <= 1'b0;
        end else begin
            if (rd_acc)
                prdata <= {rd_mux[31:12], rd_mux[11:0]};
            pready   <= psel && !penable;
            pslverr  <= psel && !penable && !mapped;
            pin_o    <= next_pin_o;
            pin_oe   <= next_pin_oe;
            spi_sclk <= bottom && pin_s[7];                   // [RULE2]
            spi_cs   <= bottom ? ctl_s[1] : 1'b1;
            spi_sdi  <= bottom && ctl_s[0];
            awake    <= wif.awake;
            irq      <= |(next_stat & mask);
        end
    end

    property p_fault_relay;
        @(posedge clk_sys) disable iff (rst)
        fault_out |=> pin_o[1] && pin_oe[1];
    endproperty
    a_fault_relay: assert property (p_fault_relay) // [RULE8]
        else $error("Fault not driven on pin 2.");

    property p_fault_or;
        @(posedge clk_sys) disable iff (rst)
        !(fault_in || local_flt) |=> !pin_o[1];
    endproperty
    a_fault_or: assert property (p_fault_or) // [RULE14]
        else $error("Fault out high with no fault source.");

    property p_lock;
        @(posedge clk_sys) disable iff (rst)
        (bottom && $stable(bottom)) |->
            cfg[17:14] == 4'h6 && cfg[3:0] == 4'h6;
    endproperty
    a_lock: assert property (p_lock) // [RULE12]
        else $error("Locked pin configuration changed at chain bottom.");

    property p_arm;
        @(posedge clk_sys) disable iff (rst)
        (!wif.awake && !(cfg[13:12] == 2'h2 && ctrl[0])) |=> !wif.awake;
    endproperty
    a_arm: assert property (p_arm) // [RULE3]
        else $error("Woke although pin 7 was not armed.");

    property p_abs;
        @(posedge clk_sys) disable iff (rst)
        (meas_ok && !ctrl[3]) |=> meas_uv == 32'($past(adc_code)) * 32'h59;
    endproperty
    a_abs: assert property (p_abs) // [RULE9]
        else $error("Absolute scaling wrong.");

    property p_no_analog_12;
        @(posedge clk_sys) disable iff (rst)
        (adc_valid && adc_pin < 4'h3) |=> $stable(meas_code);
    endproperty
    a_no_analog_12: assert property (p_no_analog_12) // [RULE11]
        else $error("Result stored for a non-analog pin.");
endmodule : gwf_top

// [sim/gwf_chain_model.sv]
// Chain neighbour model driving the pin, fault, wake and serial lines.
`timescale 1ns/1ps
module gwf_chain_model (
    // Clock.
    input  wire logic       clk_sys,
    // Device pin drive.
    input  wire logic [8:0] pin_o,
    input  wire logic [8:0] pin_oe,
    // Resolved pin levels and link pins.
    output logic      [8:0] pin_i,
    output logic            iso_link_minus_pin,
    output logic            iso_link_plus_pin
);
    logic [8:0] ext;
    logic       cs_lvl;
    logic       sdi_lvl;

    // A pin the device drives shows the device level, otherwise ours.
    assign pin_i              = (pin_oe & pin_o) | (~pin_oe & ext);
    assign iso_link_minus_pin = cs_lvl;
    assign iso_link_plus_pin  = sdi_lvl;

    initial begin
        ext     = 9'h000;
        cs_lvl  = 1'b1;
        sdi_lvl = 1'b0;
    end

    // Fault from above on pin 1 and the wake level on pin 7.
    task automatic set_pin(input int k, input logic v);
        ext[k] <= v;
    endtask : set_pin

    // Serial levels; the clock stands still low outside frames.
    task automatic set_serial(input logic sck, input logic cs, input logic d);
        ext[7]  <= sck;
        cs_lvl  <= cs;
        sdi_lvl <= d;
    endtask : set_serial
endmodule : gwf_chain_model

// [sim/gpio_wake_fault_pins_test.sv]
// Register-level test of the pin block with a chain neighbour model.
`timescale 1ns/1ps
`include "gwf_cfg.svh"
module gpio_wake_fault_pins_test;
    localparam int WC = 4;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [8:0]  pin_i;
    logic [8:0]  pin_o;
    logic [8:0]  pin_oe;
    logic        bot = 1'b0;
    logic        iso_m;
    logic        iso_p;
    logic        comm_timeout = 1'b0;
    logic [15:0] adc_code = 16'h0000;
    logic [3:0]  adc_pin = 4'h0;
    logic        adc_valid = 1'b0;
    logic        spi_sclk;
    logic        spi_cs;
    logic        spi_sdi;
    logic        spi_sdo = 1'b0;
    logic        spi_sdo_en = 1'b0;
    logic        awake;
    logic        irq;
    int          bad_count = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #20 clk_sys = ~clk_sys;

    gwf_top #(.WAKE_CYC(WC)) dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe(pin_oe), .serial_port_select_pin(bot),
        .iso_link_minus_pin(iso_m), .iso_link_plus_pin(iso_p),
        .comm_timeout(comm_timeout), .adc_code(adc_code), .adc_pin(adc_pin),
        .adc_valid(adc_valid), .spi_sclk(spi_sclk), .spi_cs(spi_cs),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_en(spi_sdo_en),
        .awake(awake), .irq(irq));

    gwf_chain_model far (.clk_sys(clk_sys), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_i(pin_i), .iso_link_minus_pin(iso_m), .iso_link_plus_pin(iso_p));

    task automatic summarize();
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // One APB transfer; data and error are taken at the pready edge.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] x, input string nm);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(nm, x, q & m);
    endtask : rdc

    task automatic wait_awake(input logic v);
        int n;
        n = 0;
        while (awake !== v && n < 30) begin
            @(posedge clk_sys);
            n++;
        end
        chk("awake", {31'h0, v}, {31'h0, awake});
    endtask : wait_awake

    task automatic pulse7(input int n);
        far.set_pin(6, 1'b1);
        cyc(n);
        far.set_pin(6, 1'b0);
        cyc(1);
    endtask : pulse7

    task automatic adc(input logic [3:0] p, input logic [15:0] c);
        @(posedge clk_sys);
        adc_pin   <= p;
        adc_code  <= c;
        adc_valid <= 1'b1;
        @(posedge clk_sys);
        adc_valid <= 1'b0;
        cyc(2);
    endtask : adc

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 20000) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        logic [31:0] q;
        logic        e;
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        chk("awake_rst", 32'h1, {31'h0, awake});
        apb(1'b0, 12'h100, 32'h0, q, e);
        chk("unmapped", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, q);
        // Pins 3 and 5 out, pins 1, 4, 6 and 7 in, pin 2 out, pin 8 analog.
        wr(`GWF_ADDR_CFG_LO, 32'h00002996);
        rdc(`GWF_ADDR_CFG_LO, 32'hFFFF, 32'h2996, "cfg_lo");
        for (int i = 0; i < 2; i++) begin
            wr(`GWF_ADDR_OUT, i ? 32'h10 : 32'h04);
            far.set_pin(3, ~i[0]);
            far.set_pin(5, i[0]);
            cyc(4);
            chk("oe", 32'h14, {23'h0, pin_oe & 9'h03C});
            chk("out", i ? 32'h10 : 32'h04, {23'h0, pin_o & 9'h014});
            rdc(`GWF_ADDR_IN, 32'h28, i ? 32'h20 : 32'h08, "in");
        end
        // Fault relay from pin 1 with interrupt, and from the local flag.
        wr(`GWF_ADDR_MASK, 32'h2);
        far.set_pin(0, 1'b1);
        cyc(6);
        chk("fault_out", 32'h3, {30'h0, pin_oe[1], pin_o[1]});
        chk("irq_fault", 32'h1, {31'h0, irq});
        far.set_pin(0, 1'b0);
        cyc(6);
        chk("fault_clr", 32'h0, {31'h0, pin_o[1]});
        rdc(`GWF_ADDR_STAT, 32'h2, 32'h2, "stat_fin");
        wr(`GWF_ADDR_STAT, 32'h2);
        cyc(2);
        chk("irq_w1c", 32'h0, {31'h0, irq});
        wr(`GWF_ADDR_CTRL, 32'h4);
        cyc(4);
        chk("local_fault", 32'h1, {31'h0, pin_o[1]});
        wr(`GWF_ADDR_CTRL, 32'h0);
        cyc(4);
        chk("local_clr", 32'h0, {31'h0, pin_o[1]});
        // Sleep and wake through pin 7.
        wr(`GWF_ADDR_MASK, 32'h1);
        wr(`GWF_ADDR_CTRL, 32'h3);
        wait_awake(1'b0);
        rdc(`GWF_ADDR_STAT, 32'h4, 32'h4, "stat_sleep");
        pulse7(WC - 2);
        cyc(20);
        chk("short_high", 32'h0, {31'h0, awake});
        pulse7(WC - 1);
        pulse7(WC - 1);
        cyc(20);
        chk("restart", 32'h0, {31'h0, awake});
        far.set_pin(6, 1'b1);
        wait_awake(1'b1);
        chk("irq_wake", 32'h1, {31'h0, irq});
        wr(`GWF_ADDR_CTRL, 32'h3);
        @(posedge clk_sys);
        comm_timeout <= 1'b1;
        cyc(2);
        comm_timeout <= 1'b0;
        cyc(20);
        chk("held_awake", 32'h1, {31'h0, awake});
        far.set_pin(6, 1'b0);
        cyc(4);
        comm_timeout <= 1'b1;
        cyc(2);
        comm_timeout <= 1'b0;
        wait_awake(1'b0);
        for (int i = 0; i < 2; i++) begin
            wr(`GWF_ADDR_CTRL, i ? 32'h1 : 32'h0);
            wr(`GWF_ADDR_CFG_LO, i ? 32'h0996 : 32'h2996);
            far.set_pin(6, 1'b1);
            cyc(20);
            chk("no_wake", 32'h0, {31'h0, awake});
            far.set_pin(6, 1'b0);
        end
        wr(`GWF_ADDR_CFG_LO, 32'h2996);
        far.set_pin(6, 1'b1);
        wait_awake(1'b1);
        far.set_pin(6, 1'b0);
        // Conversion scaling and the analog pin range.
        adc(4'h5, 16'hFFFF);
        rdc(`GWF_ADDR_ADC, 32'hFFFFF, 32'h5FFFF, "adc");
        rdc(`GWF_ADDR_MEAS, 32'hFFFFFFFF, 32'h0058FFA7, "abs");
        wr(`GWF_ADDR_CTRL, 32'h9);
        adc(4'h9, 16'h8000);
        rdc(`GWF_ADDR_MEAS, 32'hFFFFFFFF, 32'h8000, "ratio");
        for (int p = 1; p < 3; p++) begin
            adc(p[3:0], 16'h1234);
            rdc(`GWF_ADDR_ADC, 32'hFFFFF, 32'h98000, "adc_no");
        end
        // Chain bottom: serial relays and locked pins.
        bot <= 1'b1;
        spi_sdo_en <= 1'b1;
        spi_sdo <= 1'b1;
        cyc(4);
        wr(`GWF_ADDR_CFG_LO, 32'h0);
        wr(`GWF_ADDR_CFG_HI, 32'h0);
        cyc(4);
        rdc(`GWF_ADDR_CFG_LO, 32'hC00F, 32'h8006, "lock_lo");
        rdc(`GWF_ADDR_CFG_HI, 32'h3, 32'h1, "lock_hi");
        chk("lock_oe", 32'h102, {23'h0, pin_oe & 9'h187});
        chk("sdo", 32'h100, {23'h0, pin_o & 9'h100});
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            // The serial clock only moves while chip select is low.
            far.set_serial(i[0] & ~i[1], i[1], i[2]);
            spi_sdo <= i[0];
            cyc(5);
            chk("spi", {29'h0, i[2:1], i[0] & ~i[1]},
                {29'h0, spi_sdi, spi_cs, spi_sclk});
            chk("pin9", {31'h0, i[0]}, {31'h0, pin_o[8]});
        end
        summarize();
    end
endmodule : gpio_wake_fault_pins_test
